// File: design/sls_link_status_map.vh
// Register map, field positions and reset values of the link status block
`ifndef SLS_LINK_STATUS_MAP_VH
`define SLS_LINK_STATUS_MAP_VH

// ********************************************
// Register offsets (word indices, compared with address bits 5-2)
// ********************************************
`define SLS_OFS_STATUS    4'h0
`define SLS_OFS_CTRL      4'h1
`define SLS_OFS_IRQ_STAT  4'h2
`define SLS_OFS_IRQ_CLR   4'h3
`define SLS_OFS_IRQ_EN    4'h4
`define SLS_ADDR_W        6

// ********************************************
// Status register fields
// ********************************************
`define SLS_RX_LANE_HI    27
`define SLS_RX_LANE_LO    24
`define SLS_TX_LANE_HI    23
`define SLS_TX_LANE_LO    20
`define SLS_SAMPLE_HI     14
`define SLS_SAMPLE_LO     12
`define SLS_TMGR_BIT      11
`define SLS_STALL_BIT     10
`define SLS_FLOWREQ_BIT   9
`define SLS_RERR_BIT      8
`define SLS_LERR_BIT      7
`define SLS_FIFO_HI       6
`define SLS_FIFO_LO       3
`define SLS_SLV_PEND_BIT  2
`define SLS_MST_PEND_BIT  1
`define SLS_LINK_BIT      0

// ********************************************
// Control and interrupt fields
// ********************************************
`define SLS_IRQ_EN_BIT    13
`define SLS_EV_RERR       0
`define SLS_EV_LERR       1
`define SLS_EV_LINK       2
`define SLS_EV_W          3

// ********************************************
// Reset values
// ********************************************
`define SLS_RST_STATUS    32'h0000_0800
`define SLS_RST_EV        3'h0

`endif

// File: design/sls_link_status.v
// Status register bank of a multi-lane serial link port with Avalon-MM access
//
// Function
// RL1 - Reserved bits 31-28 and 19-15 read zero; writes to them are ignored.
// RL2 - Bits 27-24 show receive lanes in use, 0 to 4; 5h-Fh reserved.
// RL3 - Bits 23-20 show transmit lanes in use, 0 to 4; higher codes reserved.
// RL4 - Bits 14-12 show the live sample point of the receive timing manager.
// RL5 - Bit 11 is read-only and always one: timing manager present.
// RL6 - Peer flow enable sets bit 10 and halts transmit until peer disable.
// RL7 - Either inbound FIFO full sends a flow enable request and sets bit 9.
// RL8 - Error bits 8 and 7 clear on writing one; zero leaves them.
// RL9 - After reset all fields read zero except the presence bit, which is one.
// RL10 - Error symbol from link sets remote error; inbound packet error sets local.
// RL11 - Bit 0 is one after link initialization completes, zero otherwise.
// RL12 - Port interrupt asserts while an error flag is set and control bit 13 set.
// RL13 - Bits 6 to 3 show slave cmd, slave data, master cmd, master data nonempty.
// RL14 - Writes to read-only status fields do not change their live values.
`timescale 1ns/100ps
`include "sls_link_status_map.vh"

module sls_link_status
(
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        link_clk,
    input  wire        link_flow_on,
    input  wire        link_flow_off,
    input  wire        link_err_symbol,
    input  wire [3:0]  rx_lane_count,
    input  wire [3:0]  tx_lane_count,
    input  wire [2:0]  rx_sample_point,
    input  wire        fifo1_full,
    input  wire        fifo2_full,
    input  wire        slave_cmd_fifo_nonempty,
    input  wire        slave_data_fifo_nonempty,
    input  wire        master_cmd_fifo_nonempty,
    input  wire        master_data_fifo_nonempty,
    input  wire        slave_request_pending,
    input  wire        master_request_pending,
    input  wire        link_up,
    input  wire        pkt_error,
    output reg         inbound_flow_stall,
    output reg         outbound_flow_request,
    output reg         port_irq
);

// ********************************************
// Helpers
// ********************************************
// Sticky flag update: a set in the same cycle as its clear wins
function [`SLS_EV_W-1:0] sticky;
    input [`SLS_EV_W-1:0] cur;
    input [`SLS_EV_W-1:0] set;
    input [`SLS_EV_W-1:0] clr;
    begin
        sticky = set | (cur & ~clr);
    end
endfunction

// ********************************************
// Link domain sampling
// ********************************************
reg  [1:0] lclk_sync_ff;
reg        lclk_prev_ff;
reg  [1:0] fon_sync_ff;
reg  [1:0] foff_sync_ff;
reg  [1:0] esym_sync_ff;
wire       lclk_rise;

// Data and clock pass equal stages, so sampling at the found edge stays aligned
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        lclk_sync_ff <= 2'h0;
        lclk_prev_ff <= 1'b0;
        fon_sync_ff  <= 2'h0;
        foff_sync_ff <= 2'h0;
        esym_sync_ff <= 2'h0;
    end
    else
    begin
        lclk_sync_ff <= {lclk_sync_ff[0], link_clk};
        lclk_prev_ff <= lclk_sync_ff[1];
        fon_sync_ff  <= {fon_sync_ff[0], link_flow_on};
        foff_sync_ff <= {foff_sync_ff[0], link_flow_off};
        esym_sync_ff <= {esym_sync_ff[0], link_err_symbol};
    end
end

assign lclk_rise = lclk_sync_ff[1] & ~lclk_prev_ff;

// ********************************************
// Live status capture
// ********************************************
reg  [3:0] rx_lane_ff;
reg  [3:0] tx_lane_ff;
reg  [2:0] sample_ff;
reg  [3:0] fifo_ne_ff;
reg        slv_pend_ff;
reg        mst_pend_ff;
reg        link_ff;
reg        link_prev_ff;

// Fields follow the link logic every cycle; bus writes never reach them [RL14]
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rx_lane_ff   <= 4'h0;                                // [RL9]
        tx_lane_ff   <= 4'h0;
        sample_ff    <= 3'h0;
        fifo_ne_ff   <= 4'h0;
        slv_pend_ff  <= 1'b0;
        mst_pend_ff  <= 1'b0;
        link_ff      <= 1'b0;
        link_prev_ff <= 1'b0;
    end
    else
    begin
        // Reserved lane codes are passed through as reported [RL2] [RL3]
        rx_lane_ff   <= rx_lane_count;                       // [RL2]
        tx_lane_ff   <= tx_lane_count;                       // [RL3]
        sample_ff    <= rx_sample_point;                     // [RL4]
        fifo_ne_ff   <= {slave_cmd_fifo_nonempty,
                         slave_data_fifo_nonempty,
                         master_cmd_fifo_nonempty,
                         master_data_fifo_nonempty};         // [RL13]
        slv_pend_ff  <= slave_request_pending;
        mst_pend_ff  <= master_request_pending;
        link_ff      <= link_up;                             // [RL11]
        link_prev_ff <= link_ff;
    end
end

// ********************************************
// Flow control
// ********************************************
reg nxt_stall;

always @*
begin
    nxt_stall = inbound_flow_stall;
    if (lclk_rise && esym_sync_ff[1] == 1'b0)
    begin
        if (fon_sync_ff[1])
            nxt_stall = 1'b1;                                // [RL6]
        else if (foff_sync_ff[1])
            nxt_stall = 1'b0;                                // [RL6]
    end
end

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        inbound_flow_stall    <= 1'b0;
        outbound_flow_request <= 1'b0;
    end
    else
    begin
        inbound_flow_stall    <= nxt_stall;                  // [RL6]
        outbound_flow_request <= fifo1_full | fifo2_full;    // [RL7]
    end
end

// ********************************************
// Bus access
// ********************************************
wire [3:0] reg_idx;
wire       addr_ok;
wire       wr_take;
wire       acc_take;

assign reg_idx  = avs_address[5:2];
assign addr_ok  = (avs_address[1:0] == 2'h0);
// A request is answered at the edge that first sees it; the next edge, with waitrequest low, commits it
assign acc_take = (avs_read | avs_write) & ~avs_waitrequest;
assign wr_take  = avs_write & ~avs_waitrequest & addr_ok;

reg                 irq_en_ctl_ff;
reg                 rerr_ff;
reg                 lerr_ff;
reg [`SLS_EV_W-1:0] ev_stat_ff;
reg [`SLS_EV_W-1:0] ev_en_ff;
reg                 nxt_rerr;
reg                 nxt_lerr;
reg [`SLS_EV_W-1:0] nxt_ev_stat;
reg [`SLS_EV_W-1:0] ev_set;
reg [`SLS_EV_W-1:0] ev_clr;
reg                 rerr_set;
reg                 rerr_clr;
reg                 lerr_set;
reg                 lerr_clr;
wire [31:0]         status_word;

// Reserved ranges are fixed zeros in the read word [RL1]
assign status_word = {4'h0,                                  // [RL1]
                      rx_lane_ff,
                      tx_lane_ff,
                      5'h00,                                 // [RL1]
                      sample_ff,
                      1'b1,                                  // [RL5]
                      inbound_flow_stall,
                      outbound_flow_request,                 // [RL7]
                      rerr_ff,
                      lerr_ff,
                      fifo_ne_ff,
                      slv_pend_ff,
                      mst_pend_ff,
                      link_ff};

// ********************************************
// Error flags and event status
// ********************************************
always @*
begin
    rerr_set = lclk_rise & esym_sync_ff[1];                  // [RL10]
    lerr_set = pkt_error;                                    // [RL10]
    rerr_clr = wr_take && reg_idx == `SLS_OFS_STATUS && avs_byteenable[1]
               && avs_writedata[`SLS_RERR_BIT];              // [RL8]
    lerr_clr = wr_take && reg_idx == `SLS_OFS_STATUS && avs_byteenable[0]
               && avs_writedata[`SLS_LERR_BIT];              // [RL8]
    nxt_rerr = rerr_set | (rerr_ff & ~rerr_clr);
    nxt_lerr = lerr_set | (lerr_ff & ~lerr_clr);
    ev_set   = {`SLS_EV_W{1'b0}};
    ev_set[`SLS_EV_RERR] = rerr_set;
    ev_set[`SLS_EV_LERR] = lerr_set;
    ev_set[`SLS_EV_LINK] = link_ff ^ link_prev_ff;
    ev_clr   = {`SLS_EV_W{1'b0}};
    if (wr_take && reg_idx == `SLS_OFS_IRQ_CLR && avs_byteenable[0])
        ev_clr = avs_writedata[`SLS_EV_W-1:0];
    nxt_ev_stat = sticky(ev_stat_ff, ev_set, ev_clr);
end

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rerr_ff    <= 1'b0;
        lerr_ff    <= 1'b0;
        ev_stat_ff <= `SLS_RST_EV;
    end
    else
    begin
        rerr_ff    <= nxt_rerr;                              // [RL8]
        lerr_ff    <= nxt_lerr;                              // [RL8]
        ev_stat_ff <= nxt_ev_stat;
    end
end

// ********************************************
// Writable registers
// ********************************************
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        irq_en_ctl_ff <= 1'b0;
        ev_en_ff      <= `SLS_RST_EV;
    end
    else if (wr_take)
    begin
        if (reg_idx == `SLS_OFS_CTRL && avs_byteenable[1])
            irq_en_ctl_ff <= avs_writedata[`SLS_IRQ_EN_BIT];
        if (reg_idx == `SLS_OFS_IRQ_EN && avs_byteenable[0])
            ev_en_ff <= avs_writedata[`SLS_EV_W-1:0];
    end
end

// ********************************************
// Answer and read data
// ********************************************
reg [31:0] nxt_rdata;

always @*
begin
    nxt_rdata = 32'h0000_0000;
    if (addr_ok)
    begin
        case (reg_idx)
            `SLS_OFS_STATUS:   nxt_rdata = status_word;
            `SLS_OFS_CTRL:     nxt_rdata[`SLS_IRQ_EN_BIT] = irq_en_ctl_ff;
            `SLS_OFS_IRQ_STAT: nxt_rdata[`SLS_EV_W-1:0] = ev_stat_ff;
            `SLS_OFS_IRQ_EN:   nxt_rdata[`SLS_EV_W-1:0] = ev_en_ff;
            default:           nxt_rdata = 32'h0000_0000;
        endcase
    end
end

// Unmapped offsets are answered too: read zero, write dropped
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h0000_0000;
    end
    else if (acc_take)
    begin
        avs_waitrequest <= 1'b1;
    end
    else if (avs_read | avs_write)
    begin
        avs_waitrequest <= 1'b0;
        if (avs_read)
            avs_readdata <= nxt_rdata;
    end
end

// ********************************************
// Interrupt
// ********************************************
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        port_irq <= 1'b0;
    end
    else
    begin
        port_irq <= (irq_en_ctl_ff & (nxt_rerr | nxt_lerr))  // [RL12]
                    | (|(nxt_ev_stat & ev_en_ff));
    end
end

endmodule // sls_link_status

// File: bench/sls_link_status_checker.sv
// Assertion checker for the link status register bank
`timescale 1ns/100ps
module sls_link_status_checker
(
    input logic        core_clk,
    input logic        rst_n,
    input logic [5:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    input logic        link_flow_on,
    input logic        link_flow_off,
    input logic [3:0]  rx_lane_count,
    input logic [3:0]  tx_lane_count,
    input logic [2:0]  rx_sample_point,
    input logic        fifo1_full,
    input logic        fifo2_full,
    input logic        inbound_flow_stall,
    input logic        outbound_flow_request
);
    // ************
    // Properties
    // ************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire rd_ok = avs_read && !avs_waitrequest && avs_address == 6'h00;
    // Inputs must sit still long enough to pass the status and read stages
    sequence steady_in;
        ($stable(rx_lane_count) && $stable(tx_lane_count) && $stable(rx_sample_point))[*4];
    endsequence
    bus_answer_a:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    wait_pulse_a:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    rsvd_zero_a:
        assert property (rd_ok |-> avs_readdata[31:28] == 4'h0 && avs_readdata[19:15] == 5'h00)
        else $error("reserved status bits set");
    tmgr_one_a:
        assert property (rd_ok |-> avs_readdata[11])
        else $error("presence bit not one");
    lanes_live_a:
        assert property (steady_in ##0 rd_ok |-> avs_readdata[27:12] ==
            {rx_lane_count, tx_lane_count, 5'h00, rx_sample_point})
        else $error("lane or sample field wrong");
    outbound_flow_request_follow_a:
        assert property (outbound_flow_request == $past(fifo1_full | fifo2_full))
        else $error("flow request not following fifo full");
    stall_hold_a:
        assert property ((!link_flow_off)[*8] ##0 inbound_flow_stall |=> inbound_flow_stall)
        else $error("stall dropped without disable");
    stall_quiet_a:
        assert property ((!link_flow_on)[*8] ##0 !inbound_flow_stall |=> !inbound_flow_stall)
        else $error("stall raised without enable");
    cover property (rd_ok);
    cover property ($rose(inbound_flow_stall));
    cover property ($rose(outbound_flow_request));
endmodule // sls_link_status_checker

bind sls_link_status sls_link_status_checker i_sls_link_status_checker (.*);

// File: bench/sls_link_peer.sv
// Far-end link controller model: link clock, flow requests and error symbols
`timescale 1ns/100ps
module sls_link_peer
(
    output logic link_clk,
    output logic link_flow_on,
    output logic link_flow_off,
    output logic link_err_symbol
);
    // ************
    // Link clock and symbols
    // ************
    initial
    begin
        link_clk = 1'b0;
        link_flow_on = 1'b0;
        link_flow_off = 1'b0;
        link_err_symbol = 1'b0;
        // Odd offset keeps the link clock out of phase with the core clock
        #3;
        forever #40 link_clk = ~link_clk;
    end
    // Kind 0 flow enable, 1 flow disable, 2 error symbol; gap delays the answer
    task send(input int kind, input int gap);
        repeat (gap + 1) @(negedge link_clk);
        link_flow_on <= (kind == 0);
        link_flow_off <= (kind == 1);
        link_err_symbol <= (kind == 2);
        @(negedge link_clk);
        {link_flow_on, link_flow_off, link_err_symbol} <= 3'h0;
    endtask
endmodule // sls_link_peer

// File: bench/sls_link_status_tb_top.sv
// Self-checking testbench of the link status register bank
`timescale 1ns/100ps
module sls_link_status_tb_top;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        link_clk, link_flow_on, link_flow_off, link_err_symbol;
    logic [3:0]  rx_lane_count = 4'h0;
    logic [3:0]  tx_lane_count = 4'h0;
    logic [2:0]  rx_sample_point = 3'h0;
    logic        fifo1_full = 1'b0;
    logic        fifo2_full = 1'b0;
    logic        slave_cmd_fifo_nonempty = 1'b0, slave_data_fifo_nonempty = 1'b0;
    logic        master_cmd_fifo_nonempty = 1'b0, master_data_fifo_nonempty = 1'b0;
    logic        slave_request_pending = 1'b0, master_request_pending = 1'b0;
    logic        link_up = 1'b0;
    logic        pkt_error = 1'b0;
    logic        inbound_flow_stall, outbound_flow_request, port_irq;
    logic [31:0] rd;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc = 0;

    sls_link_status i_sls_link_status (.*);
    sls_link_peer i_sls_link_peer (.*);

    // ************
    // Clock, timeout and common tasks
    // ************
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            conclude;
        end
    end
    task conclude;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One Avalon access; w=1 writes, read data lands in rd
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        avs_byteenable <= be;
        // Waits as long as the slave needs; only the bench timeout ends a hang
        do
        begin
            @(posedge core_clk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task peer(input int kind, input int gap);
        i_sls_link_peer.send(kind, gap);
        @(posedge core_clk);
    endtask
    function logic [31:0] st(input logic [11:0] lo);
        return {4'h0, rx_lane_count, tx_lane_count, 5'h00, rx_sample_point, lo};
    endfunction

    // ************
    // Scenarios
    // ************
    task t_fields;
        bus(0, 6'h00, 32'h0, 4'hf);
        chk(rd, 32'h0000_0800);
        bus(0, 6'h3c, 32'h0, 4'hf);
        chk(rd, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            rx_lane_count <= 4'(i);
            tx_lane_count <= 4'(6 - i);
            rx_sample_point <= 3'(i + 2);
            {slave_cmd_fifo_nonempty, slave_data_fifo_nonempty, master_cmd_fifo_nonempty,
                master_data_fifo_nonempty, slave_request_pending, master_request_pending,
                link_up} <= 7'h1 << i;
            repeat (3) @(posedge core_clk);
            bus(0, 6'h00, 32'h0, 4'hf);
            chk(rd, st({5'h10, 7'h1 << i}));
        end
        bus(1, 6'h00, 32'hffff_ffff, 4'hf);
        bus(0, 6'h00, 32'h0, 4'hf);
        chk(rd, st(12'h840));
    endtask
    task t_outbound_flow_request;
        for (int i = 1; i < 5; i++)
        begin
            {fifo2_full, fifo1_full} <= 2'(i % 4);
            repeat (3) @(posedge core_clk);
            bus(0, 6'h00, 32'h0, 4'hf);
            chk({rd[9], outbound_flow_request}, (i < 4) ? 32'h3 : 32'h0);
        end
    endtask
    task t_flow;
        peer(0, 0);
        repeat (40) if (inbound_flow_stall !== 1'b1) @(posedge core_clk);
        bus(0, 6'h00, 32'h0, 4'hf);
        chk({rd[10], inbound_flow_stall}, 32'h3);
        peer(1, 3);
        repeat (40) if (inbound_flow_stall !== 1'b0) @(posedge core_clk);
        bus(0, 6'h00, 32'h0, 4'hf);
        chk({rd[10], inbound_flow_stall}, 32'h0);
    endtask
    task t_err;
        peer(2, 0);
        pkt_error <= 1'b1;
        @(posedge core_clk);
        pkt_error <= 1'b0;
        repeat (8) @(posedge core_clk);
        bus(1, 6'h00, 32'h0, 4'hf);
        bus(0, 6'h00, 32'h0, 4'hf);
        chk({rd[8:7], port_irq}, 32'h6);
        bus(1, 6'h04, 32'h2000, 4'hf);
        bus(1, 6'h00, 32'h100, 4'h2);
        bus(0, 6'h00, 32'h0, 4'hf);
        chk({rd[8:7], port_irq}, 32'h3);
        bus(1, 6'h00, 32'h80, 4'h1);
        repeat (2) @(posedge core_clk);
        chk(port_irq, 32'h0);
        bus(0, 6'h08, 32'h0, 4'hf);
        chk(rd & 32'h3, 32'h3);
        bus(1, 6'h10, 32'h3, 4'hf);
        // Interrupt is registered one cycle after the enable lands
        @(posedge core_clk);
        chk(port_irq, 32'h1);
        bus(1, 6'h10, 32'h0, 4'hf);
        @(posedge core_clk);
        chk(port_irq, 32'h0);
        bus(1, 6'h10, 32'h3, 4'hf);
        bus(1, 6'h0c, 32'h7, 4'hf);
        bus(0, 6'h08, 32'h0, 4'hf);
        chk(rd, 32'h0);
        chk(port_irq, 32'h0);
        bus(0, 6'h0c, 32'h0, 4'hf);
        chk(rd, 32'h0);
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_fields;
        t_outbound_flow_request;
        t_flow;
        t_err;
        conclude;
    end
endmodule // sls_link_status_tb_top
